// File: common/gate_seq_pkg.sv
package gate_seq_pkg;
	localparam int unsigned CLK_FREQ_MHZ = 200;
	// Strong-current window after a gate-enable command, in nanoseconds.
	localparam int unsigned DRIVE_TIMEOUT_NS = 4000;
	localparam int unsigned DRIVE_TIMEOUT_CYC =
		(DRIVE_TIMEOUT_NS * CLK_FREQ_MHZ + 999) / 1000;
	// Strong low-side pull-down window covering the switch-node slew.
	localparam int unsigned SLEW_HOLD_NS = 1000;
	localparam int unsigned SLEW_HOLD_CYC =
		(SLEW_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int unsigned TIMER_W = 16;

	// Drive strength applied to one gate.
	typedef enum logic [1:0] {
		GATE_OFF_WEAK,
		GATE_OFF_STRONG,
		GATE_ON_STRONG,
		GATE_ON_HOLD
	} gate_drive_t;

	// Comparator results for one transistor.
	typedef struct packed {
		logic gate_voltage_monitor;
		logic drain_voltage_monitor;
	} fet_monitor_t;

	// Comparator settings, from serial port or hardwired inputs.
	typedef struct packed {
		logic [3:0] drain_threshold;
		logic [3:0] gate_threshold;
	} comp_cfg_t;

	// Fault flags for one transistor.
	typedef struct packed {
		logic stuck_low;
		logic stuck_high;
		logic overcurrent;
	} fet_fault_t;
endpackage

// File: hw/half_bridge_gate_sequencer.sv
// Functional notes
// - New transistor enables only after the opposite gate monitor reads off.
// - Handshake applies both low-to-high and high-to-low directions.
// - Gate-on command selects strong source current and starts drive timer.
// - No gate rise at timer expiry flags fault and turns drive off.
// - Gate risen at timer expiry switches to small holding current.
// - Drive timer bounds the strong current duration on any gate.
// - Stuck-low and stuck-high gates on each transistor are reported faults.
// - Low-side gate held with strong pull-down during high-side slew.
// - After the slew window, low-side moves to the weak pull-down.
// - Each gate has own drain and gate comparator inputs for faults.
// - Comparator settings come from serial or hardwired source, selectable.
`timescale 1ns/1ps
module half_bridge_gate_sequencer
	import gate_seq_pkg::*;
#(
	parameter logic [TIMER_W-1:0] DRIVE_CYC = TIMER_W'(DRIVE_TIMEOUT_CYC),
	parameter logic [TIMER_W-1:0] SLEW_CYC = TIMER_W'(SLEW_HOLD_CYC)
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic cmd_high_in,
	input wire logic cmd_enable_in,
	input wire logic fault_clear_in,
	input wire fet_monitor_t hs_mon_in,
	input wire fet_monitor_t ls_mon_in,
	input wire logic cfg_sel_serial_in,
	input wire comp_cfg_t cfg_serial_in,
	input wire comp_cfg_t cfg_hardwired_in,
	output gate_drive_t hs_drive_out,
	output gate_drive_t ls_drive_out,
	output comp_cfg_t comp_cfg_out,
	output fet_fault_t hs_fault_out,
	output fet_fault_t ls_fault_out,
	output logic gate_fault_out
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_LS_OFF,
		ST_HS_DRIVE,
		ST_HS_HOLD,
		ST_WAIT_HS_OFF,
		ST_LS_DRIVE,
		ST_LS_HOLD,
		ST_FAULT
	} seq_state_t;

	seq_state_t state_q;
	seq_state_t state_d;
	logic [TIMER_W-1:0] gate_drive_timer_q;
	logic [TIMER_W-1:0] slew_q;
	logic timer_start;
	logic gate_drive_timeout;
	logic hs_sel;
	logic ls_sel;
	gate_drive_t hs_d;
	gate_drive_t ls_d;
	fet_fault_t hs_f_d;
	fet_fault_t ls_f_d;
	comp_cfg_t cfg_d;

	assign gate_drive_timeout = (gate_drive_timer_q == '0);
	assign hs_sel = cmd_enable_in && cmd_high_in;
	assign ls_sel = cmd_enable_in && !cmd_high_in;

	always_comb begin
		state_d = state_q;
		timer_start = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				// Timing the wait lets a gate that never turns off be flagged.
				timer_start = hs_sel || ls_sel;
				if (hs_sel) begin
					state_d = ST_WAIT_LS_OFF;
				end else if (ls_sel) begin
					state_d = ST_WAIT_HS_OFF;
				end
			end
			ST_WAIT_LS_OFF: begin
				if (!hs_sel) begin
					state_d = ST_IDLE;
				end else if (!ls_mon_in.gate_voltage_monitor) begin
					state_d = ST_HS_DRIVE;
					timer_start = 1'b1;
				end
			end
			ST_WAIT_HS_OFF: begin
				if (!ls_sel) begin
					state_d = ST_IDLE;
				end else if (!hs_mon_in.gate_voltage_monitor) begin
					state_d = ST_LS_DRIVE;
					timer_start = 1'b1;
				end
			end
			ST_HS_DRIVE: begin
				if (!hs_sel) begin
					state_d = ST_IDLE;
				end else if (gate_drive_timeout) begin
					state_d = hs_mon_in.gate_voltage_monitor ?
						ST_HS_HOLD : ST_FAULT;
				end
			end
			ST_LS_DRIVE: begin
				if (!ls_sel) begin
					state_d = ST_IDLE;
				end else if (gate_drive_timeout) begin
					state_d = ls_mon_in.gate_voltage_monitor ?
						ST_LS_HOLD : ST_FAULT;
				end
			end
			ST_HS_HOLD: begin
				if (!hs_sel) begin
					state_d = ST_IDLE;
				end
			end
			ST_LS_HOLD: begin
				if (!ls_sel) begin
					state_d = ST_IDLE;
				end
			end
			ST_FAULT: begin
				// Drive stays off until software clears, so a shorted gate
				// never sees repeated strong pulses.
				if (fault_clear_in) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			gate_drive_timer_q <= '0;
		end else if (timer_start) begin
			gate_drive_timer_q <= DRIVE_CYC - TIMER_W'(1);
		end else if (!gate_drive_timeout) begin
			gate_drive_timer_q <= gate_drive_timer_q - TIMER_W'(1);
		end
	end

	// Slew window opens when the high side starts driving.
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			slew_q <= '0;
		end else if (timer_start && state_q == ST_WAIT_LS_OFF) begin
			slew_q <= SLEW_CYC;
		end else if (slew_q != '0) begin
			slew_q <= slew_q - TIMER_W'(1);
		end
	end

	always_comb begin
		hs_d = GATE_OFF_WEAK;
		ls_d = GATE_OFF_WEAK;
		unique case (state_d)
			ST_HS_DRIVE: hs_d = GATE_ON_STRONG;
			ST_HS_HOLD: hs_d = GATE_ON_HOLD;
			ST_LS_DRIVE: ls_d = GATE_ON_STRONG;
			ST_LS_HOLD: ls_d = GATE_ON_HOLD;
			default: begin
				hs_d = GATE_OFF_WEAK;
				ls_d = GATE_OFF_WEAK;
			end
		endcase
		if ((state_d == ST_HS_DRIVE || state_d == ST_HS_HOLD) &&
			(slew_q > TIMER_W'(1) || timer_start)) begin
			ls_d = GATE_OFF_STRONG;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			hs_drive_out <= GATE_OFF_WEAK;
			ls_drive_out <= GATE_OFF_WEAK;
		end else begin
			hs_drive_out <= hs_d;
			ls_drive_out <= ls_d;
		end
	end

	// Sticky faults; a new event wins over a clear in the same cycle.
	always_comb begin
		hs_f_d = fault_clear_in ? '0 : hs_fault_out;
		ls_f_d = fault_clear_in ? '0 : ls_fault_out;
		if (state_q == ST_HS_DRIVE && gate_drive_timeout &&
			!hs_mon_in.gate_voltage_monitor) begin
			hs_f_d.stuck_low = 1'b1;
		end
		if (state_q == ST_LS_DRIVE && gate_drive_timeout &&
			!ls_mon_in.gate_voltage_monitor) begin
			ls_f_d.stuck_low = 1'b1;
		end
		// A gate still on a full drive window after its own drive went off.
		if (state_q == ST_WAIT_HS_OFF && gate_drive_timeout &&
			hs_mon_in.gate_voltage_monitor && hs_drive_out == GATE_OFF_WEAK) begin
			hs_f_d.stuck_high = 1'b1;
		end
		if (state_q == ST_WAIT_LS_OFF && gate_drive_timeout &&
			ls_mon_in.gate_voltage_monitor && ls_drive_out == GATE_OFF_WEAK) begin
			ls_f_d.stuck_high = 1'b1;
		end
		if (hs_mon_in.drain_voltage_monitor && hs_drive_out == GATE_ON_HOLD) begin
			hs_f_d.overcurrent = 1'b1;
		end
		if (ls_mon_in.drain_voltage_monitor && ls_drive_out == GATE_ON_HOLD) begin
			ls_f_d.overcurrent = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			hs_fault_out <= '0;
			ls_fault_out <= '0;
			gate_fault_out <= 1'b0;
		end else begin
			hs_fault_out <= hs_f_d;
			ls_fault_out <= ls_f_d;
			gate_fault_out <= (|hs_f_d) || (|ls_f_d);
		end
	end

	assign cfg_d = cfg_sel_serial_in ? cfg_serial_in : cfg_hardwired_in;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			comp_cfg_out <= '0;
		end else begin
			comp_cfg_out <= cfg_d;
		end
	end
endmodule

// File: verification/fet_pair_model.sv
`timescale 1ns/1ps
module fet_pair_model
	import gate_seq_pkg::*;
(
	input wire logic core_clk_in,
	input wire gate_drive_t hs_drive_in,
	input wire gate_drive_t ls_drive_in,
	input wire logic hs_short_in,
	input wire logic ls_oc_in,
	input wire logic ls_stuck_in,
	output fet_monitor_t hs_mon_out,
	output fet_monitor_t ls_mon_out
);
	// Gates charge a cycle after sourcing; a shorted gate never rises.
	always_ff @(posedge core_clk_in) begin
		hs_mon_out.gate_voltage_monitor <= hs_drive_in[1] && !hs_short_in;
		ls_mon_out.gate_voltage_monitor <= ls_drive_in[1] || ls_stuck_in;
		hs_mon_out.drain_voltage_monitor <= 1'b0;
		ls_mon_out.drain_voltage_monitor <= ls_oc_in && ls_drive_in[1];
	end
endmodule

// File: verification/gate_seq_monitor.sv
`timescale 1ns/1ps
module gate_seq_monitor
	import gate_seq_pkg::*;
#(
	parameter logic [TIMER_W-1:0] DRIVE_CYC = TIMER_W'(DRIVE_TIMEOUT_CYC)
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire fet_monitor_t hs_mon_in,
	input wire fet_monitor_t ls_mon_in,
	input wire gate_drive_t hs_drive_out,
	input wire gate_drive_t ls_drive_out,
	input wire fet_fault_t hs_fault_out,
	input wire fet_fault_t ls_fault_out,
	input wire logic gate_fault_out
);
	logic [TIMER_W-1:0] strong_q;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence hs_on;
		$rose(hs_drive_out == GATE_ON_STRONG);
	endsequence
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in || hs_drive_out != GATE_ON_STRONG) begin
			strong_q <= '0;
		end else begin
			strong_q <= strong_q + TIMER_W'(1);
		end
	end
	a_no_shoot: assert property (!(hs_drive_out[1] && ls_drive_out[1]))
		else $error("both gates on");
	a_hs_waits: assert property (hs_on |->
		$past(!ls_mon_in.gate_voltage_monitor)) else $error("early high");
	a_strong_max: assert property (hs_drive_out == GATE_ON_STRONG |->
		strong_q < DRIVE_CYC) else $error("strong too long");
	a_hold_ok: assert property ($past(hs_drive_out == GATE_ON_STRONG) &&
		hs_drive_out == GATE_ON_HOLD |-> $past(hs_mon_in.gate_voltage_monitor))
		else $error("hold without rise");
	a_low_fault: assert property ($rose(hs_fault_out.stuck_low) |->
		hs_drive_out == GATE_OFF_WEAK) else $error("fault left drive on");
	a_fault_sum: assert property (gate_fault_out ==
		(|{hs_fault_out, ls_fault_out})) else $error("fault summary wrong");
	a_slew_pull: assert property (hs_on |-> ls_drive_out == GATE_OFF_STRONG
		##[1:1000] ls_drive_out == GATE_OFF_WEAK) else $error("pull-down");
	a_oc_flag: assert property (ls_drive_out == GATE_ON_HOLD &&
		ls_mon_in.drain_voltage_monitor |=> ls_fault_out.overcurrent)
		else $error("overcurrent missed");
endmodule
bind half_bridge_gate_sequencer gate_seq_monitor #(.DRIVE_CYC(DRIVE_CYC)) mon (
	.core_clk_in, .nrst_in, .hs_mon_in, .ls_mon_in, .hs_drive_out,
	.ls_drive_out, .hs_fault_out, .ls_fault_out, .gate_fault_out);

// File: verification/test_half_bridge_gate_sequencer.sv
`timescale 1ns/1ps
module test_half_bridge_gate_sequencer;
	import gate_seq_pkg::*;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hi = 1'b0, en = 1'b0, clr = 1'b0, sel = 1'b0, sh = 1'b0, oc = 1'b0;
	logic st = 1'b0;
	fet_monitor_t hm, lm;
	gate_drive_t hd, ld;
	comp_cfg_t cfg;
	fet_fault_t hf, lf;
	logic flt;
	int n_errors = 0, cmp_count = 0;
	half_bridge_gate_sequencer #(.DRIVE_CYC(16'h0004), .SLEW_CYC(16'h0002)) dut (
		.core_clk_in(core_clk_in), .nrst_in(nrst_in), .cmd_high_in(hi),
		.cmd_enable_in(en), .fault_clear_in(clr), .hs_mon_in(hm), .ls_mon_in(lm),
		.cfg_sel_serial_in(sel), .cfg_serial_in(8'h5A), .cfg_hardwired_in(8'hC3),
		.hs_drive_out(hd), .ls_drive_out(ld), .comp_cfg_out(cfg),
		.hs_fault_out(hf), .ls_fault_out(lf), .gate_fault_out(flt));
	fet_pair_model fets (.core_clk_in(core_clk_in), .hs_drive_in(hd),
		.ls_drive_in(ld), .hs_short_in(sh), .ls_oc_in(oc), .hs_mon_out(hm),
		.ls_mon_out(lm), .ls_stuck_in(st));
	initial forever #2.5 core_clk_in = ~core_clk_in;
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task run(input logic e, input logic h, input int n);
		@(posedge core_clk_in);
		en <= e;
		hi <= h;
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task t_clr;
		@(posedge core_clk_in);
		{en, sh, oc, st} <= 4'h0;
		// Let the gates settle first, so no fault event lands on the clear.
		repeat (3) @(posedge core_clk_in);
		clr <= 1'b1;
		@(posedge core_clk_in);
		clr <= 1'b0;
		run(1'b0, 1'b0, 2);
		chk("cleared", 8'(flt), 8'h00);
	endtask
	task t_cfg;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_in);
			sel <= i[0];
			run(1'b0, 1'b0, 2);
			chk("cfg", cfg, i ? 8'h5A : 8'hC3);
		end
	endtask
	task t_swap;
		run(1'b1, 1'b0, 12);
		chk("ls hold", 8'(ld), 8'(GATE_ON_HOLD));
		run(1'b1, 1'b1, 12);
		chk("hs hold", 8'(hd), 8'(GATE_ON_HOLD));
		chk("ls weak", 8'(ld), 8'(GATE_OFF_WEAK));
		run(1'b1, 1'b0, 12);
		chk("ls again", 8'(ld), 8'(GATE_ON_HOLD));
		chk("hs off", 8'(hd), 8'(GATE_OFF_WEAK));
	endtask
	task t_short;
		run(1'b0, 1'b0, 4);
		@(posedge core_clk_in);
		sh <= 1'b1;
		run(1'b1, 1'b1, 12);
		chk("stuck low", 8'(hf), 8'h04);
		chk("fault", 8'(flt), 8'h01);
		chk("hs shut", 8'(hd), 8'(GATE_OFF_WEAK));
		t_clr;
	endtask
	task t_oc;
		run(1'b1, 1'b0, 12);
		@(posedge core_clk_in);
		oc <= 1'b1;
		run(1'b1, 1'b0, 3);
		chk("overcurrent", 8'(lf), 8'h01);
		t_clr;
	endtask
	task t_stuck;
		@(posedge core_clk_in);
		st <= 1'b1;
		run(1'b1, 1'b1, 12);
		chk("stuck high", 8'(lf), 8'h02);
		chk("hs blocked", 8'(hd), 8'(GATE_OFF_WEAK));
		t_clr;
	endtask
	task test_done;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge core_clk_in);
		n_errors++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		t_cfg;
		t_swap;
		t_short;
		t_oc;
		t_stuck;
		test_done;
	end
endmodule
